// *** rtl/flash_sector_protection.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sector_protection_cfg.svh"
module flash_sector_protection (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic tool_socket_i, // pin: part sits in a programming tool
  input wire logic debug_session_i, // pin: serial_debug_session_mode active
  input wire logic vpp_ok_i, // pin: programming supply present
  input wire logic req_i, // core access request, held until ack_o
  input wire logic we_i, // core access is a write
  input wire logic [15:0] addr_i, // core byte address
  input wire logic [7:0] wdata_i, // core write data
  input wire logic lvd_request_i, // software wants supply_drop_detector
  output logic [7:0] rdata_o, // read data, valid with ack_o
  output logic ack_o, // access done, one cycle
  output logic busy_o, // erase sequence running
  output logic readout_protect_o, // protection in force
  output logic supply_drop_detector_en_o, // detector enable
  output logic board_test_download_o, // RAM test download allowed
  output logic software_driven_programming_o // no tool mode present
);
  // reset release through two flops
  logic rst_ff1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  // pin synchronisers
  logic [`PIN_N-1:0] pin_ff1;
  logic [`PIN_N-1:0] pin_s;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_ff1 <= '0;
      pin_s <= '0;
    end else if (ce_i) begin
      pin_ff1 <= {vpp_ok_i, debug_session_i, tool_socket_i};
      pin_s <= pin_ff1;
    end
  end

  flash_mem_if mif ();
  flash_array u_array (
    .clk_i (clk_i),
    .ce_i (ce_i),
    .mif (mif)
  );

  // state
  flash_sector_protection_pkg::op_state_e state; // sequencer state
  flash_sector_protection_pkg::op_state_e next_state;
  logic [`CMD_W-1:0] cmd; // armed command bits
  logic key1_seen; // first guard key written
  logic armed; // guard open for one command write
  logic err; // sticky refusal flag
  logic [15:0] ptr; // erase address
  logic [15:0] erase_hi; // last erase address
  logic opt_pend; // option write follows erase
  logic [7:0] opt_hold; // option value to write
  logic protect; // latched protection
  logic captured; // protection sampled since reset
  logic rd_pend; // read in flight
  logic rd_mem; // read answer comes from array
  logic [7:0] rd_fixed; // read answer not from array

  // mode decode; the tool enters a debug session itself
  wire tool_mode = pin_s[`PIN_SOCKET] | pin_s[`PIN_DEBUG];
  wire vpp = pin_s[`PIN_VPP];
  wire idle = (state == flash_sector_protection_pkg::op_idle);
  wire take = req_i & ~ack_o & ~rd_pend & idle;
  wire is_flash_op_ctrl_status = (addr_i == `FLASH_OP_CTRL_STATUS_ADDR);
  wire in_flash = (addr_i >= `FLASH_BASE);
  wire has_one = (`FLASH_KBYTES >= 8);
  wire has_two = (`FLASH_KBYTES > 8);

  // sector decode: two 4K sectors at top, rest below
  wire flash_sector_protection_pkg::sector_t tgt =
    (addr_i >= `SECT0_BASE) ? `SECT_BOOT :
    (addr_i >= `SECT1_BASE) ? (has_one ? `SECT_ONE : `SECT_NONE) :
    (in_flash && has_two) ? `SECT_TWO : `SECT_NONE;
  wire tgt_ok = (tgt != `SECT_NONE);
  wire [15:0] sect_lo = (tgt == `SECT_BOOT) ? `SECT0_BASE :
    (tgt == `SECT_ONE) ? `SECT1_BASE : `FLASH_BASE;
  wire [15:0] sect_hi = (tgt == `SECT_BOOT) ? `ADDR_TOP :
    (tgt == `SECT_ONE) ? `SECT1_TOP : `SECT2_TOP;

  // command qualification; software mode cannot touch sector 0
  wire wr_flash = take & we_i & ~is_flash_op_ctrl_status & in_flash;
  wire sect_ok = vpp & tgt_ok & (tool_mode | (tgt != `SECT_BOOT));
  wire tool_ok = vpp & tool_mode;
  wire do_pgm = wr_flash & cmd[`BIT_PGM] & sect_ok;
  wire do_ser = wr_flash & ~cmd[`BIT_PGM] & cmd[`BIT_SER] & sect_ok;
  wire sel_mer = ~cmd[`BIT_PGM] & ~cmd[`BIT_SER] & cmd[`BIT_MER];
  wire do_mer = wr_flash & sel_mer & tool_ok;
  wire sel_opt = ~cmd[`BIT_PGM] & ~cmd[`BIT_SER] & ~cmd[`BIT_MER] & cmd[`BIT_OPT];
  wire do_opt = wr_flash & sel_opt & tool_ok;
  wire unprotect = do_opt & protect & wdata_i[`OPT_RP_BIT];
  wire opt_now = do_opt & ~unprotect;
  wire refuse = wr_flash & ~(do_pgm | do_ser | do_mer | do_opt);
  wire erase_last = (state == flash_sector_protection_pkg::op_erase) && (ptr == erase_hi);
  wire op_done = do_pgm | opt_now | (erase_last & ~opt_pend) |
    (state == flash_sector_protection_pkg::op_opt_write);

  // guard register writes
  wire flash_op_ctrl_status_wr = take & we_i & is_flash_op_ctrl_status;
  wire key1_hit = flash_op_ctrl_status_wr & (wdata_i == `GUARD_KEY1);
  wire key2_hit = flash_op_ctrl_status_wr & key1_seen & (wdata_i == `GUARD_KEY2);
  wire cmd_wr = flash_op_ctrl_status_wr & armed & ~key1_hit;
  wire [7:0] flash_op_ctrl_status_val = {~idle, err, 1'b0, armed, cmd};

  // read path
  wire rd_take = take & ~we_i;
  wire rd_hidden = tool_mode & (protect | ~captured);
  wire [7:0] next_rd_fixed = is_flash_op_ctrl_status ? flash_op_ctrl_status_val : `HIDDEN_BYTE;

  // array port drive; erase writes blank bytes over a range
  wire erasing = (state == flash_sector_protection_pkg::op_erase);
  assign mif.we = do_pgm | erasing;
  assign mif.waddr = erasing ? ptr[`FLASH_AW-1:0] : addr_i[`FLASH_AW-1:0];
  assign mif.wdata = erasing ? `ERASED_BYTE : wdata_i;
  assign mif.raddr = addr_i[`FLASH_AW-1:0];
  assign mif.opt_we = opt_now | (state == flash_sector_protection_pkg::op_opt_write);
  assign mif.opt_wdata = opt_now ? wdata_i : opt_hold;

  // option sample: strap on mask parts, option bit otherwise
  wire opt_protect = `MASK_PART ? `MASK_PROTECT : ~mif.opt_q[`OPT_RP_BIT];

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      flash_sector_protection_pkg::op_idle: begin
        if (do_ser | do_mer | unprotect) begin
          next_state = flash_sector_protection_pkg::op_erase;
        end
      end
      flash_sector_protection_pkg::op_erase: begin
        if (erase_last) begin
          next_state = opt_pend ? flash_sector_protection_pkg::op_opt_write
                                : flash_sector_protection_pkg::op_idle;
        end
      end
      flash_sector_protection_pkg::op_opt_write: begin
        next_state = flash_sector_protection_pkg::op_idle;
      end
      default: begin
        next_state = flash_sector_protection_pkg::op_idle;
      end
    endcase
  end

  // sequencer and erase pointer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= flash_sector_protection_pkg::op_idle;
      ptr <= `FLASH_BASE;
      erase_hi <= `FLASH_BASE;
      opt_pend <= 1'b0;
      opt_hold <= `ERASED_BYTE;
    end else if (ce_i) begin
      state <= next_state;
      if (do_ser) begin // single sector range
        ptr <= sect_lo;
        erase_hi <= sect_hi;
      end else if (do_mer | unprotect) begin // whole array
        ptr <= `FLASH_BASE;
        erase_hi <= `ADDR_TOP;
      end else if (erasing) begin
        ptr <= ptr + 16'h0001;
      end
      if (unprotect) begin
        opt_pend <= 1'b1;
        opt_hold <= wdata_i;
      end else if (op_done) begin
        opt_pend <= 1'b0;
      end
    end
  end

  // guard and command register; a finished op relocks
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      key1_seen <= 1'b0;
      armed <= 1'b0;
      cmd <= `CMD_NONE;
    end else if (ce_i) begin
      if (flash_op_ctrl_status_wr) begin
        key1_seen <= key1_hit;
      end
      if (key2_hit) begin
        armed <= 1'b1;
      end else if (flash_op_ctrl_status_wr) begin
        armed <= 1'b0;
      end
      if (cmd_wr) begin
        cmd <= wdata_i[`CMD_W-1:0];
      end else if (op_done) begin
        cmd <= `CMD_NONE;
      end
    end
  end

  // refusal flag: set wins over the clear by key one
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else if (ce_i) begin
      err <= refuse | (err & ~key1_hit);
    end
  end

  // protection sampled once after reset release
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      protect <= 1'b0;
      captured <= 1'b0;
    end else if (ce_i && !captured) begin
      protect <= opt_protect;
      captured <= 1'b1;
    end
  end

  // access answers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      rd_mem <= 1'b0;
      rd_fixed <= `FLASH_OP_CTRL_STATUS_RESET;
      ack_o <= 1'b0;
      rdata_o <= `FLASH_OP_CTRL_STATUS_RESET;
    end else if (ce_i) begin
      rd_pend <= rd_take;
      if (rd_take) begin
        rd_mem <= in_flash & ~is_flash_op_ctrl_status & ~rd_hidden;
        rd_fixed <= next_rd_fixed;
      end
      ack_o <= (take & we_i) | rd_pend;
      if (rd_pend) begin
        rdata_o <= rd_mem ? mif.rdata : rd_fixed;
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
      readout_protect_o <= 1'b0;
      supply_drop_detector_en_o <= 1'b0;
      board_test_download_o <= 1'b0;
      software_driven_programming_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (next_state != flash_sector_protection_pkg::op_idle);
      readout_protect_o <= protect;
      supply_drop_detector_en_o <= lvd_request_i & captured & ~protect;
      board_test_download_o <= pin_s[`PIN_DEBUG];
      software_driven_programming_o <= ~tool_mode;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence seq_unprotect_req;
    ce_i && unprotect;
  endsequence
  sequence seq_full_erase_start;
    erasing && (ptr == `FLASH_BASE) && (erase_hi == `ADDR_TOP);
  endsequence

  chk_boot_refuse_flag: assert property (
    (ce_i && wr_flash && !tool_mode && tgt == `SECT_BOOT) |=> err)
    else $error("boot sector write in software mode not flagged");
  chk_boot_refuse_keep: assert property (
    (wr_flash && !tool_mode && tgt == `SECT_BOOT) |-> (!mif.we && !mif.opt_we && next_state == state))
    else $error("refused boot write modified array or started an op");
  chk_guard_locked: assert property (
    (wr_flash && cmd == `CMD_NONE) |-> (!mif.we && !mif.opt_we))
    else $error("flash modified without guard command");
  chk_erase_in_sector: assert property (
    erasing |-> (ptr >= `FLASH_BASE && ptr <= erase_hi))
    else $error("erase pointer left its range");
  chk_erase_blank: assert property (
    mif.we |-> (erasing ? mif.wdata == `ERASED_BYTE : mif.wdata == wdata_i))
    else $error("wrong write data to array");
  chk_boot_decode: assert property (
    (addr_i >= `SECT0_BASE) |-> (tgt == `SECT_BOOT && sect_hi == `ADDR_TOP))
    else $error("boot sector decode wrong");
  chk_sector_two: assert property (
    (in_flash && addr_i < `SECT1_BASE) |-> (tgt == `SECT_TWO))
    else $error("third sector not decoded");
  chk_tool_boot_pgm: assert property (
    (wr_flash && tool_mode && vpp && cmd[`BIT_PGM] && tgt == `SECT_BOOT) |-> mif.we)
    else $error("tool mode could not program boot sector");
  chk_unprotect_erase: assert property (
    seq_unprotect_req |=> seq_full_erase_start)
    else $error("protection removal did not start full erase");
  chk_prot_stable: assert property (
    (captured && $past(captured)) |-> $stable(protect))
    else $error("protection changed before reset");
  chk_lvd_blocked: assert property (
    (ce_i && protect) |=> !supply_drop_detector_en_o)
    else $error("detector enabled under protection");
  chk_hidden_read: assert property (
    (ce_i && rd_take && in_flash && !is_flash_op_ctrl_status && rd_hidden) ##1 ce_i |=> (ack_o && rdata_o == `HIDDEN_BYTE))
    else $error("protected array read by tool");
  chk_flash_op_ctrl_status_reset: assert property (
    $rose(rst_n) |-> (flash_op_ctrl_status_val == `FLASH_OP_CTRL_STATUS_RESET))
    else $error("control register not 00h after reset");
endmodule : flash_sector_protection
`default_nettype wire

// *** rtl/flash_sector_protection_cfg.svh ***
`ifndef FLASH_SECTOR_PROTECTION_CFG_SVH
`define FLASH_SECTOR_PROTECTION_CFG_SVH
// array size and address layout
`define FLASH_KBYTES 32
`define FLASH_AW 15
`define FLASH_BASE 16'h8000
`define SECT1_BASE 16'hE000
`define SECT0_BASE 16'hF000
`define SECT1_TOP 16'hEFFF
`define SECT2_TOP 16'hDFFF
`define ADDR_TOP 16'hFFFF
// sector codes
`define SECT_BOOT 2'h0
`define SECT_ONE 2'h1
`define SECT_TWO 2'h2
`define SECT_NONE 2'h3
// flash op control/status register
`define FLASH_OP_CTRL_STATUS_ADDR 16'h0029
`define FLASH_OP_CTRL_STATUS_RESET 8'h00
`define BIT_PGM 0
`define BIT_SER 1
`define BIT_MER 2
`define BIT_OPT 3
`define BIT_ARMED 4
`define BIT_ERR 6
`define BIT_BUSY 7
`define CMD_W 4
`define CMD_NONE 4'h0
// guard key sequence
`define GUARD_KEY1 8'h56
`define GUARD_KEY2 8'hAE
// option byte and data values
`define OPT_RP_BIT 0
`define ERASED_BYTE 8'hFF
`define HIDDEN_BYTE 8'h00
// mask-programmed variant straps
`define MASK_PART 1'b0
`define MASK_PROTECT 1'b0
// synchronised pin positions
`define PIN_SOCKET 0
`define PIN_DEBUG 1
`define PIN_VPP 2
`define PIN_N 3
`endif

// *** rtl/flash_sector_protection_pkg.sv ***
package flash_sector_protection_pkg;
  // sector number of an address
  typedef logic [1:0] sector_t;
  // sequencer states
  typedef enum logic [1:0] {
    op_idle,
    op_erase,
    op_opt_write
  } op_state_e;
endpackage : flash_sector_protection_pkg

// *** rtl/flash_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sector_protection_cfg.svh"
interface flash_mem_if;
  logic we; // byte write strobe
  logic [`FLASH_AW-1:0] waddr; // write index
  logic [7:0] wdata; // write byte
  logic [`FLASH_AW-1:0] raddr; // read index
  logic [7:0] rdata; // registered read byte
  logic opt_we; // option byte write strobe
  logic [7:0] opt_wdata; // option byte value
  logic [7:0] opt_q; // stored option byte
  modport ctrl (output we, waddr, wdata, raddr, opt_we, opt_wdata, input rdata, opt_q);
  modport mem (input we, waddr, wdata, raddr, opt_we, opt_wdata, output rdata, opt_q);
endinterface : flash_mem_if
`default_nettype wire

// *** rtl/flash_array.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sector_protection_cfg.svh"
module flash_array (
  input wire logic clk_i, // system clock
  input wire logic ce_i, // clock enable
  flash_mem_if.mem mif // port from the controller
);
  // nonvolatile cells: no reset, contents survive system reset
  logic [7:0] cells [0:(1<<`FLASH_AW)-1];
  logic [7:0] opt_cell = `ERASED_BYTE; // leaves the factory blank, so unprotected

  // byte write, registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (mif.we) begin
        cells[mif.waddr] <= mif.wdata;
      end
      mif.rdata <= cells[mif.raddr];
    end
  end

  // option byte cell
  always_ff @(posedge clk_i) begin
    if (ce_i && mif.opt_we) begin
      opt_cell <= mif.opt_wdata;
    end
  end
  assign mif.opt_q = opt_cell;
endmodule : flash_array
`default_nettype wire

// *** tb/prog_tool_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side: programming tool in a socket, in-circuit tool, or a board supply only
module prog_tool_model (
  input wire logic clk_i, // system clock
  input wire logic [1:0] mode_i, // 0 none, 1 socket, 2 in-circuit, 3 software with supply
  output logic tool_socket_o = 1'b0, // part sits in the tool
  output logic debug_session_o = 1'b0, // serial debug session held
  output logic vpp_ok_o = 1'b0 // programming supply on
);
  // pins move off the sampling edge; in-circuit supply waits for the session to be up
  always @(negedge clk_i) begin
    tool_socket_o <= (mode_i == 2'h1);
    debug_session_o <= (mode_i == 2'h2);
    vpp_ok_o <= (mode_i == 2'h1) | (mode_i == 2'h3) | ((mode_i == 2'h2) & debug_session_o);
  end
endmodule : prog_tool_model
`default_nettype wire

// *** tb/flash_sector_protection_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_sector_protection_test;
  typedef struct packed {logic rd; logic [7:0] mask; logic [7:0] val;} note_s;
  logic clk_i = 1'b0; // 25 MHz clock
  logic rst_n_i = 1'b0; // reset, active low
  logic ce_i = 1'b1; // clock enable
  logic req_i = 1'b0; // core request
  logic we_i = 1'b0; // write flag
  logic [15:0] addr_i = 16'h0000; // byte address
  logic [7:0] wdata_i = 8'h00; // write byte
  logic lvd_request_i = 1'b1; // detector wanted
  logic [1:0] mode = 2'h1; // tool mode code
  logic tool_socket, debug_session, vpp_ok; // tool pins
  logic [7:0] rdata_o; // read byte
  logic ack_o, busy_o, readout_protect_o, supply_drop_detector_en_o; // status outputs
  logic board_test_download_o, software_driven_programming_o; // mode outputs
  note_s notes[$]; // expected answers in request order
  note_s cur; // note being compared
  int failures = 0; // mismatches
  int checks_done = 0; // comparisons
  int cycles = 0; // run length
  int n; // busy length
  logic [7:0] d0, d1, d2; // random payload bytes

  prog_tool_model prog_tool_model_inst (.clk_i(clk_i), .mode_i(mode),
    .tool_socket_o(tool_socket), .debug_session_o(debug_session), .vpp_ok_o(vpp_ok));

  flash_sector_protection flash_sector_protection_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .tool_socket_i(tool_socket), .debug_session_i(debug_session),
    .vpp_ok_i(vpp_ok), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .lvd_request_i(lvd_request_i), .rdata_o(rdata_o), .ack_o(ack_o), .busy_o(busy_o),
    .readout_protect_o(readout_protect_o),
    .supply_drop_detector_en_o(supply_drop_detector_en_o),
    .board_test_download_o(board_test_download_o),
    .software_driven_programming_o(software_driven_programming_o));

  // clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // verdict and end of run
  task finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // one byte comparison
  task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  // one core access, held until acknowledged; the answer is noted for the monitor
  task access(input logic wr, input logic [15:0] a, input logic [7:0] d,
              input logic [7:0] m, input logic [7:0] e);
    int k;
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = wr;
    addr_i = a;
    wdata_i = d;
    notes.push_back({~wr, m, e});
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 40000);
    // keep the request up through the edge that samples ack high
    @(negedge clk_i);
    req_i = 1'b0;
  endtask : access

  task wr(input logic [15:0] a, input logic [7:0] d);
    access(1'b1, a, d, 8'h00, 8'h00);
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00, 8'hFF, e);
  endtask : rd

  // key pair then command into the op control register
  task arm(input logic [7:0] cmd);
    wr(16'h0029, 8'h56);
    wr(16'h0029, 8'hAE);
    wr(16'h0029, cmd);
  endtask : arm

  // reset pulse of five cycles, then settle time for sync and sampling
  task do_reset;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask : do_reset

  // length of a busy period, bounded
  task wait_busy(output int cnt);
    cnt = 0;
    while (busy_o === 1'b1 && cnt < 40000) begin
      @(negedge clk_i);
      cnt++;
    end
  endtask : wait_busy

  // monitor: every acknowledge takes the oldest note
  always @(negedge clk_i) begin
    if (ack_o === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("FAIL ack expected none seen 1");
      end else begin
        cur = notes.pop_front();
        if (cur.rd) begin
          check8("read data", cur.val, rdata_o & cur.mask);
        end
      end
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      $display("FAIL run length expected below 90000 seen 90000");
      finish_test();
    end
  end

  // main sequence
  initial begin
    void'($urandom(35));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    do_reset();
    check8("protect", 8'h00, {7'h0, readout_protect_o});
    check8("lvd on", 8'h01, {7'h0, supply_drop_detector_en_o});
    lvd_request_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check8("lvd off", 8'h00, {7'h0, supply_drop_detector_en_o});
    rd(16'h0029, 8'h00);
    // socket tool programs boot sector, sector 1 and sector 2
    arm(8'h01);
    wr(16'hF000, d0);
    arm(8'h01);
    wr(16'hE000, d1);
    arm(8'h01);
    wr(16'h8000, d2);
    rd(16'hF000, d0);
    rd(16'hE000, d1);
    rd(16'h8000, d2);
    rd(16'h0029, 8'h00);
    wr(16'hF000, ~d0);
    rd(16'hF000, d0);
    // in-circuit session
    mode = 2'h2;
    repeat (8) @(negedge clk_i);
    check8("board test", 8'h01, {7'h0, board_test_download_o});
    check8("sw mode", 8'h00, {7'h0, software_driven_programming_o});
    // application mode: boot sector refused, error flagged
    mode = 2'h3;
    repeat (8) @(negedge clk_i);
    check8("sw mode", 8'h01, {7'h0, software_driven_programming_o});
    check8("board test", 8'h00, {7'h0, board_test_download_o});
    arm(8'h01);
    wr(16'hF000, ~d0);
    rd(16'hF000, d0);
    access(1'b0, 16'h0029, 8'h00, 8'h40, 8'h40);
    arm(8'h02);
    wr(16'hF000, 8'h00);
    rd(16'hF000, d0);
    // sector 1 erase leaves its neighbours alone
    arm(8'h02);
    wr(16'hE000, 8'h00);
    wait_busy(n);
    checks_done++;
    if (n < 4090 || n > 4100) begin
      failures++;
      $display("FAIL erase cycles expected 4096 seen %0d", n);
    end
    rd(16'hE000, 8'hFF);
    rd(16'hEFFF, 8'hFF);
    rd(16'hF000, d0);
    rd(16'h8000, d2);
    // protection switched on through the option byte
    mode = 2'h1;
    lvd_request_i = 1'b1;
    repeat (8) @(negedge clk_i);
    // whole array erase in tool mode, frozen for 100 cycles by the clock enable
    arm(8'h04);
    wr(16'h8000, 8'h00);
    ce_i = 1'b0;
    repeat (100) @(negedge clk_i);
    ce_i = 1'b1;
    wait_busy(n);
    checks_done++;
    if (n < 32762 || n > 32772) begin
      failures++;
      $display("FAIL mass erase cycles expected 32767 seen %0d", n);
    end
    rd(16'hF000, 8'hFF);
    rd(16'h8000, 8'hFF);
    arm(8'h08);
    wr(16'h8000, 8'hFE);
    wait_busy(n);
    do_reset();
    check8("protect", 8'h01, {7'h0, readout_protect_o});
    check8("lvd on", 8'h00, {7'h0, supply_drop_detector_en_o});
    rd(16'h8000, 8'h00);
    rd(16'hF000, 8'h00);
    // lifting protection wipes the array first
    arm(8'h08);
    wr(16'h8000, 8'hFF);
    wait_busy(n);
    check8("protect", 8'h01, {7'h0, readout_protect_o});
    do_reset();
    check8("protect", 8'h00, {7'h0, readout_protect_o});
    rd(16'hF000, 8'hFF);
    rd(16'h8000, 8'hFF);
    rd(16'hE000, 8'hFF);
    finish_test();
  end
endmodule : flash_sector_protection_test
`default_nettype wire
